/* vslf_pkg.sv */
// Constants and types shared by the video serdes line framer
package vslf_pkg;
  localparam int COLOR_W = 24; // Colour lane width
  localparam int SYM_W = 10; // One 8b/10b code group
  localparam int FIFO_DEPTH = 4; // Pixel words buffered ahead of coder
  localparam logic [1:0] DIV_LAST = 2'h2; // Three code groups per pixel
  localparam logic [1:0] SIDE_LINES = 2'h2; // Blanking lines for side data
  localparam logic [2:0] STRAP_RST = 3'h0; // Straps read as low until sync
  localparam logic [2:0] K_SIDE = 3'h4; // Index of side-slot comma
  // Five-bit group codes at negative disparity
  localparam logic [5:0] T6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // Three-bit group codes at negative disparity
  localparam logic [3:0] T4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] T4_ALT7 = 4'h7; // Alternate x.7 group
  // Control groups at negative disparity: none, line, frame, both, side
  localparam logic [SYM_W-1:0] K_SYM [5] = '{
    10'h0f4, 10'h0f9, 10'h0f5, 10'h0f3, 10'h0fa};
  // One pixel of parallel video, syncs active high inside the block
  typedef struct packed {
    logic [COLOR_W-1:0] color_lanes;
    logic frame_sync;
    logic line_sync;
    logic video_data_valid;
  } vslf_video_t;
  // Code-group position within a pixel
  typedef enum logic [1:0] {
    SYM0 = 2'b00,
    SYM1 = 2'b01,
    SYM2 = 2'b10
  } vslf_phase_t;
  // Differential serial pair, one code group per clock
  typedef struct packed {
    logic [SYM_W-1:0] serial_pair_pos;
    logic [SYM_W-1:0] serial_pair_neg;
  } vslf_serial_t;
endpackage : vslf_pkg

/* vslf_fifo.sv */
// Small pixel FIFO with valid/ready on both sides
`timescale 1ns/1ps
module vslf_fifo #(
  parameter int W = 27,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } vslf_fifo_st_t;
  vslf_fifo_st_t st_ff;
  vslf_fifo_st_t nxt_st;
  logic push;
  logic pop;

  assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_ff.cnt != '0;
  assign out_data = st_ff.mem[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : vslf_fifo

/* vslf_top.sv */
// Video serdes line framer: 8b/10b pixel serializer and deserializer
`timescale 1ns/1ps
// Summary of operation
// - Direction strap alone picks serializer or deserializer
// - Video pins input when serializing, driven otherwise
// - Each pixel sent as thirty serial bits
// - Every byte coded 8b/10b, DC balanced
// - Side slots in two blanking lines, and whenever the FIFO is empty
// - Receiver may shift timing in front porch
// - Polarity straps choose sync active levels
// - Status high while valid code groups arrive
// - Deserializer drives recovered pixel clock out
module vslf_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic video_tx_sel, // Strap: high serializer
  input wire logic line_sync_polarity, // Strap: high active low
  input wire logic frame_sync_polarity, // Strap: high active low
  input wire logic side_channel_en, // Side channel enable
  input vslf_pkg::vslf_video_t video_i, // Video pins as seen
  output vslf_pkg::vslf_video_t video_o, // Video pins driven
  output logic video_oe, // Video pins driven by us
  input vslf_pkg::vslf_serial_t serial_i, // Serial pair as seen
  output vslf_pkg::vslf_serial_t serial_o, // Serial pair driven
  output logic serial_oe, // Serial pair driven by us
  output logic recovered_clk, // Recovered pixel clock
  output logic rx_status, // Valid code groups seen
  output logic side_window // Side channel slot open
);
  import vslf_pkg::*;

  // Whole block state
  typedef struct packed {
    logic [2:0] strap_s1; // Straps: dir, line pol, frame pol
    logic [2:0] strap_s2;
    logic [2:0] strap_s3;
    logic [2:0] strap; // Accepted strap levels
    logic [1:0] div; // Pixel-rate divider
    vslf_video_t cap; // Captured pixel, syncs active high
    logic cap_vld; // Captured pixel waits for FIFO
    vslf_phase_t tph; // Transmit group position
    vslf_video_t tword; // Pixel being sent
    logic tside; // Pixel slot is a side slot
    logic trd; // Transmit running disparity
    logic [SYM_W-1:0] tsym; // Group on the line
    logic [SYM_W-1:0] rx1; // Serial input synchroniser
    logic [SYM_W-1:0] rx2;
    logic [SYM_W-1:0] rx3;
    logic [SYM_W-1:0] rxs; // Accepted received group
    vslf_phase_t rph; // Receive group position
    logic rprevk; // Last group was control or bad
    logic [15:0] rbuf; // First two colour bytes
    vslf_video_t vout; // Output pixel, syncs active high
    logic stat; // Receiver status
    logic rclk; // Recovered clock level
    logic [1:0] lines; // Lines seen in frame sync
    logic lprev; // Line sync last cycle
    logic swin; // Side slot open
  } vslf_state_t;

  vslf_state_t st_ff;
  vslf_state_t nxt_st;
  logic mode_ser; // Serializer mode
  logic pix_en; // One pulse per pixel
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  vslf_video_t fifo_out;
  logic [9:0] dec_r; // Decoded group: ok, control, byte
  logic [7:0] tx_byte; // Colour byte for this group
  logic [10:0] tx_enc; // Coded byte and next disparity
  logic [2:0] k_idx; // Control group index
  vslf_phase_t rx_ph; // Effective receive position
  logic src_line; // Sync sources for side slot
  logic src_frame;

  ////////////////////////////////////////////////////////////////////////
  // 8b/10b coding

  // Code one byte at a running disparity; returns {rd, group}
  function automatic logic [10:0] enc8(input logic [7:0] d,
                                       input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r;
    s6 = T6[d[4:0]];
    r = rd;
    if ((($countones(s6) != 3) || (d[4:0] == 5'h07)) && rd) begin
      s6 = ~s6;
    end
    if ($countones(s6) != 3) begin
      r = ~r;
    end
    s4 = T4[d[7:5]];
    // Alternate x.7 avoids a run of five
    if ((d[7:5] == 3'h7) && ((!r && (d[4:0] == 5'h11 ||
        d[4:0] == 5'h12 || d[4:0] == 5'h14)) || (r &&
        (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)))) begin
      s4 = T4_ALT7;
    end
    if ((($countones(s4) != 2) || (d[7:5] == 3'h3)) && r) begin
      s4 = ~s4;
    end
    if ($countones(s4) != 2) begin
      r = ~r;
    end
    return {r, s6, s4};
  endfunction : enc8

  // Look a group up; returns {ok, control, byte or index}
  function automatic logic [9:0] dec10(input logic [SYM_W-1:0] s);
    logic [9:0] r;
    logic [10:0] e;
    r = '0;
    for (int k = 0; k < 5; k++) begin
      if (s == K_SYM[k] || s == ~K_SYM[k]) begin
        r = {2'b11, 5'h00, 3'(k)};
      end
    end
    for (int d = 0; d < 256; d++) begin
      for (int p = 0; p < 2; p++) begin
        e = enc8(8'(d), p[0]);
        if (e[9:0] == s) begin
          r = {2'b10, 8'(d)};
        end
      end
    end
    return r;
  endfunction : dec10

  ////////////////////////////////////////////////////////////////////////
  // Pixel buffer between capture and coder

  vslf_fifo #(
    .W($bits(vslf_video_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data(st_ff.cap),
    .in_valid(st_ff.cap_vld),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  assign mode_ser = st_ff.strap[0];
  assign pix_en = st_ff.div == DIV_LAST;
  assign fifo_out_ready = mode_ser && (st_ff.tph == SYM2);
  assign dec_r = dec10(st_ff.rxs);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_st = st_ff;
    tx_byte = '0;
    tx_enc = '0;
    k_idx = '0;
    rx_ph = st_ff.rph;
    // Straps: accepted once the two late stages agree
    nxt_st.strap_s1 = {frame_sync_polarity, line_sync_polarity,
                       video_tx_sel};
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.strap_s3 = st_ff.strap_s2;
    for (int i = 0; i < 3; i++) begin
      if (st_ff.strap_s2[i] == st_ff.strap_s3[i]) begin
        nxt_st.strap[i] = st_ff.strap_s3[i];
      end
    end
    // Pixel-rate enable
    nxt_st.div = pix_en ? 2'h0 : st_ff.div + 2'h1;
    // Capture a pixel; a full FIFO stalls capture
    if (pix_en && mode_ser && (!st_ff.cap_vld || fifo_in_ready)) begin
      nxt_st.cap = video_i;
      nxt_st.cap.line_sync = video_i.line_sync ^ st_ff.strap[1];
      nxt_st.cap.frame_sync = video_i.frame_sync ^ st_ff.strap[2];
      nxt_st.cap_vld = 1'b1;
    end else if (fifo_in_ready) begin
      nxt_st.cap_vld = 1'b0;
    end
    // Side slot: first two lines while frame sync is active
    src_line = mode_ser ? st_ff.cap.line_sync : st_ff.vout.line_sync;
    src_frame = mode_ser ? st_ff.cap.frame_sync : st_ff.vout.frame_sync;
    nxt_st.lprev = src_line;
    if (!src_frame) begin
      nxt_st.lines = 2'h0;
    end else if (src_line && !st_ff.lprev && st_ff.lines != SIDE_LINES) begin
      nxt_st.lines = st_ff.lines + 2'h1;
    end
    nxt_st.swin = side_channel_en && src_frame &&
                  (nxt_st.lines != SIDE_LINES);
    // Transmitter: three groups per pixel
    if (mode_ser) begin
      unique case (st_ff.tph)
        SYM0: nxt_st.tph = SYM1;
        SYM1: nxt_st.tph = SYM2;
        SYM2: begin
          nxt_st.tph = SYM0;
          nxt_st.tword = fifo_out_valid ? fifo_out : '0;
          // Empty or blanking slot in window carries side slot
          nxt_st.tside = !fifo_out_valid || (st_ff.swin &&
                         !fifo_out.video_data_valid);
        end
        default: nxt_st.tph = SYM0; // Illegal code recovers
      endcase
      unique case (nxt_st.tph)
        SYM0: tx_byte = nxt_st.tword.color_lanes[23:16];
        SYM1: tx_byte = nxt_st.tword.color_lanes[15:8];
        default: tx_byte = nxt_st.tword.color_lanes[7:0];
      endcase
      if (nxt_st.tword.video_data_valid && !nxt_st.tside) begin
        tx_enc = enc8(tx_byte, st_ff.trd);
        nxt_st.tsym = tx_enc[9:0];
        nxt_st.trd = tx_enc[10];
      end else begin
        k_idx = nxt_st.tside ? K_SIDE : {1'b0, nxt_st.tword.frame_sync,
                                         nxt_st.tword.line_sync};
        // Unbalanced control groups flip the running disparity
        nxt_st.tsym = st_ff.trd ? ~K_SYM[k_idx] : K_SYM[k_idx];
        nxt_st.trd = st_ff.trd ^ ($countones(K_SYM[k_idx]) != 5);
      end
    end else begin
      nxt_st.tph = SYM0;
    end
    // Serial input: three stages; a new group each clock, so no vote
    nxt_st.rx1 = serial_i.serial_pair_pos;
    nxt_st.rx2 = st_ff.rx1;
    nxt_st.rx3 = st_ff.rx2;
    nxt_st.rxs = st_ff.rx3;
    // Receiver: first data after control starts a pixel
    if (!mode_ser) begin
      if (dec_r[9] && !dec_r[8] && st_ff.rprevk) begin
        rx_ph = SYM0;
      end
      unique case (rx_ph)
        SYM0: nxt_st.rph = SYM1;
        SYM1: nxt_st.rph = SYM2;
        SYM2: nxt_st.rph = SYM0;
        default: nxt_st.rph = SYM0; // Illegal code recovers
      endcase
      nxt_st.stat = dec_r[9];
      nxt_st.rclk = rx_ph != SYM2;
      nxt_st.rprevk = !dec_r[9] || dec_r[8];
      if (!dec_r[9]) begin
        nxt_st.vout.video_data_valid = 1'b0;
      end else if (dec_r[8]) begin
        nxt_st.vout.video_data_valid = 1'b0;
        // Side slot holds the syncs, stretching the porch
        if (dec_r[2:0] != K_SIDE) begin
          nxt_st.vout.frame_sync = dec_r[1];
          nxt_st.vout.line_sync = dec_r[0];
        end
      end else begin
        unique case (rx_ph)
          SYM0: nxt_st.rbuf[15:8] = dec_r[7:0];
          SYM1: nxt_st.rbuf[7:0] = dec_r[7:0];
          default: begin
            nxt_st.vout.color_lanes = {st_ff.rbuf, dec_r[7:0]};
            nxt_st.vout.video_data_valid = 1'b1;
            nxt_st.vout.frame_sync = 1'b0;
            nxt_st.vout.line_sync = 1'b0;
          end
        endcase
      end
    end else begin
      nxt_st.stat = 1'b0;
      nxt_st.rclk = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.strap <= STRAP_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign video_oe = !mode_ser;
  assign serial_oe = mode_ser;
  assign video_o.color_lanes = st_ff.vout.color_lanes;
  assign video_o.video_data_valid = st_ff.vout.video_data_valid;
  assign video_o.line_sync = st_ff.vout.line_sync ^ st_ff.strap[1];
  assign video_o.frame_sync = st_ff.vout.frame_sync ^ st_ff.strap[2];
  assign serial_o.serial_pair_pos = st_ff.tsym;
  assign serial_o.serial_pair_neg = ~st_ff.tsym;
  assign recovered_clk = st_ff.rclk;
  assign rx_status = st_ff.stat;
  assign side_window = st_ff.swin;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence strap_high_s;
    video_tx_sel [*5];
  endsequence
  sequence tx_cycle_s;
    st_ff.tph == SYM1 ##1 (st_ff.tph == SYM2 || !$past(serial_oe));
  endsequence

  strap_mode_a: assert property (
    strap_high_s |-> serial_oe)
    else $error("Serializer not chosen by strap");
  pin_dir_a: assert property (
    video_oe != serial_oe)
    else $error("Video and serial drive overlap");
  pix_cycle_a: assert property (
    serial_oe && $past(serial_oe) && st_ff.tph == SYM0
    |=> tx_cycle_s)
    else $error("Pixel not three code groups");
  dc_balance_a: assert property (
    serial_oe && $past(serial_oe) |->
    ($countones(st_ff.tsym) inside {4, 5, 6}) &&
    (($countones(st_ff.tsym) != 6) || !$past(st_ff.trd)) &&
    (($countones(st_ff.tsym) != 4) || $past(st_ff.trd)))
    else $error("Code group breaks disparity");
  side_gate_a: assert property (
    !side_channel_en |=> !side_window)
    else $error("Side slot open while disabled");
  side_hold_a: assert property (
    video_oe && $past(video_oe) && dec_r[9] && dec_r[8] &&
    dec_r[2:0] == K_SIDE |=> $stable(st_ff.vout.frame_sync))
    else $error("Side slot moved frame sync");
  sync_pol_a: assert property (
    pix_en && serial_oe && st_ff.strap[1] && !video_i.line_sync &&
    (!st_ff.cap_vld || fifo_in_ready) |=> st_ff.cap.line_sync)
    else $error("Active low line sync lost");
  rx_stat_a: assert property (
    video_oe && $past(video_oe) |=> rx_status == $past(dec_r[9]))
    else $error("Status disagrees with decode");
  rclk_off_a: assert property (
    serial_oe && $past(serial_oe) |-> !recovered_clk)
    else $error("Recovered clock runs in serializer");
endmodule : vslf_top

/* vslf_partner_model.sv */
// Far-side serdes model: decodes our groups and sends groups to us
`timescale 1ns/1ps
module vslf_partner_model (
  input wire logic sys_clk,
  input wire logic rst,
  input vslf_pkg::vslf_serial_t line_i, // Pair as driven by block
  input wire logic line_oe, // Block drives the pair
  output vslf_pkg::vslf_serial_t line_o // Pair driven by model
);
  import vslf_pkg::*;
  logic [8:0] rx_q [$]; // Decoded groups: {control, value}
  logic [11:0] tx_q [$]; // Queued groups: {kind, value}
  int bad_cnt = 0; // Illegal, unbalanced or skewed groups
  int disp = 0; // Running ones-minus-five sum
  logic rd_ff = 1'b0; // Transmit disparity, high positive
  logic [9:0] g; // Decode result
  logic [9:0] gt; // Group being sent
  logic [11:0] t; // Queue entry being sent
  // Byte to code group at a given disparity
  function automatic logic [9:0] enc(input logic [7:0] b, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r;
    s6 = T6[b[4:0]];
    if (rd && ($countones(s6) != 3 || b[4:0] == 5'h07)) s6 = ~s6;
    r = rd ^ ($countones(s6) != 3);
    s4 = T4[b[7:5]];
    if (b[7:5] == 3'h7 && (r ? (b[4:0] inside {11, 13, 14}) :
        (b[4:0] inside {17, 18, 20}))) s4 = T4_ALT7;
    if (r && ($countones(s4) != 2 || b[7:5] == 3'h3)) s4 = ~s4;
    return {s6, s4};
  endfunction : enc
  // Group to {legal, control, value}; either disparity accepted
  function automatic logic [9:0] dec(input logic [9:0] c);
    for (int k = 0; k < 5; k++) begin
      if (c == K_SYM[k] || c == ~K_SYM[k]) return {2'h3, k[7:0]};
    end
    for (int k = 0; k < 256; k++) begin
      if (c == enc(k[7:0], 1'b0) || c == enc(k[7:0], 1'b1)) begin
        return {2'h2, k[7:0]};
      end
    end
    return 10'h0;
  endfunction : dec
  // Receive: decode, check the pair and DC balance
  always @(posedge sys_clk) begin
    if (!rst && line_oe) begin
      g = dec(line_i.serial_pair_pos);
      if (g[9] !== 1'b1) bad_cnt++;
      if (line_i.serial_pair_neg !== ~line_i.serial_pair_pos) bad_cnt++;
      disp += $countones(line_i.serial_pair_pos) - 5;
      if (disp > 1 || disp < -1) bad_cnt++;
      rx_q.push_back(g[8:0]);
    end
  end
  // Transmit: one group a clock, comma fill when idle
  always @(posedge sys_clk) begin
    // Control groups sent at the running disparity
    gt = rd_ff ? ~K_SYM[K_SIDE] : K_SYM[K_SIDE];
    if (tx_q.size() > 0 && !line_oe) begin
      t = tx_q.pop_front();
      // Kind 0 data, 1 control index, 2 raw group
      if (t[11:10] == 2'h2) gt = t[9:0];
      else if (t[11:10] == 2'h1) gt = rd_ff ? ~K_SYM[t[2:0]] : K_SYM[t[2:0]];
      else gt = enc(t[7:0], rd_ff);
    end
    line_o <= {gt, ~gt};
    rd_ff = rd_ff ^ ($countones(gt) != 5);
  end
endmodule : vslf_partner_model

/* vslf_testbench.sv */
// Self-checking bench for the video serdes line framer
`timescale 1ns/1ps
module testbench;
  import vslf_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic video_tx_sel = 1'b0;
  logic line_sync_polarity = 1'b0;
  logic frame_sync_polarity = 1'b0;
  logic side_channel_en = 1'b0;
  vslf_video_t vid_drv = '0; // Video pins from the source
  vslf_video_t video_i;
  vslf_video_t video_o;
  vslf_serial_t serial_i;
  vslf_serial_t serial_o;
  vslf_serial_t far_o;
  logic video_oe, serial_oe, recovered_clk, rx_status, side_window;
  int n_errors = 0;
  int checks_done = 0;
  int sw_cnt = 0; // Cycles with side slot open
  logic [23:0] pix [4] = '{24'h000000, 24'hffffff, 24'h123456, 24'hf1eb07};

  always #25 sys_clk = ~sys_clk;
  // Wire levels from whichever party drives
  assign video_i = video_oe ? video_o : vid_drv;
  assign serial_i = serial_oe ? serial_o : far_o;
  always @(posedge sys_clk) if (side_window === 1'b1) sw_cnt++;

  vslf_top i_dut (.sys_clk(sys_clk), .rst(rst), .video_tx_sel(video_tx_sel),
    .line_sync_polarity(line_sync_polarity),
    .frame_sync_polarity(frame_sync_polarity),
    .side_channel_en(side_channel_en), .video_i(video_i), .video_o(video_o),
    .video_oe(video_oe), .serial_i(serial_i), .serial_o(serial_o),
    .serial_oe(serial_oe), .recovered_clk(recovered_clk),
    .rx_status(rx_status), .side_window(side_window));
  vslf_partner_model i_far (.sys_clk(sys_clk), .rst(rst), .line_i(serial_o),
    .line_oe(serial_oe), .line_o(far_o));

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Verdict and end of run
  task automatic final_report;
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Settle to falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // One pixel held for three clocks
  task automatic send_pix(input vslf_video_t v);
    @(posedge sys_clk) vid_drv <= v;
    repeat (2) @(posedge sys_clk);
  endtask : send_pix
  // Blanking pixel; sync pins at strap-chosen level
  task automatic send_blank(input logic l, input logic f);
    send_pix({24'h0, f ^ frame_sync_polarity, l ^ line_sync_polarity, 1'b0});
  endtask : send_blank
  // Queue groups at the far side
  task automatic push(input logic [11:0] e, input int n);
    repeat (n) i_far.tx_q.push_back(e);
  endtask : push

  ////////////////////////////////////////////////////////////////////////
  // Levels held during reset
  task automatic test_reset;
    check("video_oe", video_oe, 1);
    check("serial_oe", serial_oe, 0);
    check("rx_status", rx_status, 0);
    $display("test reset done");
  endtask : test_reset
  // Serializer: sync codes, pixel bytes, balance
  task automatic test_tx_stream;
    logic [8:0] exp [$];
    int hit;
    int ok;
    video_tx_sel <= 1'b1;
    line_sync_polarity <= 1'b1;
    cyc(12);
    check("serial_oe", serial_oe, 1);
    check("video_oe", video_oe, 0);
    i_far.rx_q.delete();
    i_far.bad_cnt = 0;
    i_far.disp = 0;
    sw_cnt = 0;
    for (int c = 0; c < 4; c++) begin
      send_blank(c[0], c[1]);
      repeat (3) exp.push_back({7'h40, c[1:0]});
    end
    for (int p = 0; p < 4; p++) begin
      send_pix({pix[p], 1'b0 ^ frame_sync_polarity, 1'b1, 1'b1});
      for (int b = 2; b >= 0; b--) exp.push_back({1'b0, pix[p][b*8 +: 8]});
    end
    repeat (2) send_blank(1'b0, 1'b0);
    cyc(30);
    hit = 0;
    for (int i = 0; i + exp.size() <= i_far.rx_q.size(); i++) begin
      ok = 1;
      foreach (exp[j]) if (i_far.rx_q[i + j] !== exp[j]) ok = 0;
      if (ok == 1) hit = 1;
    end
    check("tx_stream", hit, 1);
    check("tx_bad_groups", i_far.bad_cnt, 0);
    check("side_closed", sw_cnt, 0);
    $display("test tx_stream done");
  endtask : test_tx_stream
  // Side slot only in frame blanking
  task automatic test_side;
    int kc;
    @(posedge sys_clk);
    side_channel_en <= 1'b1;
    i_far.rx_q.delete();
    sw_cnt = 0;
    for (int n = 0; n < 12; n++) send_blank(n % 4 == 1, 1'b1);
    repeat (2) send_blank(1'b0, 1'b0);
    cyc(20);
    kc = 0;
    foreach (i_far.rx_q[i]) if (i_far.rx_q[i] === {6'h20, K_SIDE}) kc++;
    check("side_open", sw_cnt != 0, 1);
    check("side_comma", kc != 0, 1);
    check("side_after", side_window, 0);
    sw_cnt = 0;
    for (int p = 0; p < 4; p++) begin
      send_pix({pix[p], frame_sync_polarity, 1'b1, 1'b1});
    end
    check("side_in_video", sw_cnt, 0);
    check("tx_bad_groups", i_far.bad_cnt, 0);
    side_channel_en <= 1'b0;
    $display("test side done");
  endtask : test_side
  // Deserializer: pixel, syncs, status, recovered clock
  task automatic test_rx;
    int hi;
    video_tx_sel <= 1'b0;
    frame_sync_polarity <= 1'b1;
    cyc(12);
    check("serial_oe", serial_oe, 0);
    check("video_oe", video_oe, 1);
    push(12'h400, 3);
    push(12'h0a5, 1);
    push(12'h05a, 1);
    push(12'h03c, 1);
    push(12'h400, 3);
    for (int i = 0; i < 40 && video_o.video_data_valid !== 1'b1; i++) cyc(1);
    check("rx_color", video_o.color_lanes, 24'ha55a3c);
    check("rx_status", rx_status, 1);
    hi = 0;
    for (int i = 0; i < 30; i++) begin
      cyc(1);
      if (recovered_clk === 1'b1) hi++;
    end
    check("rec_clk_high", hi, 20);
    push(12'h401, 3);
    cyc(12);
    check("rx_line_pin", video_o.line_sync, 0);
    check("rx_frame_pin", video_o.frame_sync, 1);
    check("rx_valid", video_o.video_data_valid, 0);
    push(12'h402, 3);
    cyc(12);
    check("rx_line_pin", video_o.line_sync, 1);
    check("rx_frame_pin", video_o.frame_sync, 0);
    push(12'h800, 3);
    for (int i = 0; i < 20 && rx_status !== 1'b0; i++) cyc(1);
    check("rx_status_bad", rx_status, 0);
    check("rx_valid_bad", video_o.video_data_valid, 0);
    cyc(10);
    check("rx_status_back", rx_status, 1);
    $display("test rx done");
  endtask : test_rx

  ////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    #250000;
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    final_report;
  end
  // Main sequence
  initial begin
    cyc(4);
    test_reset;
    cyc(4);
    @(posedge sys_clk) rst <= 1'b0;
    test_tx_stream;
    test_side;
    test_rx;
    final_report;
  end
endmodule : testbench
